/* dcc_cal.sv */
// temperature calibration cycle timer
`timescale 1ns/1ps
`default_nettype none

module dcc_cal
  import dcc_pkg::*;
#(
  parameter int CYCLES = CAL_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic cal_enable,
  input  wire logic cal_start,
  output logic      cal_busy,
  output logic      cal_done
);

  localparam int CW = $clog2(CYCLES + 1);

  dcc_cal_state_type state_r;
  logic [CW-1:0]     count_r;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r  <= CAL_IDLE;
      count_r  <= '0;
      cal_done <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        CAL_IDLE:
        begin
          // a trigger with calibration disabled does nothing
          if (cal_start && cal_enable) // see (RL6) see (RL7)
          begin
            state_r  <= CAL_RUN;
            count_r  <= CW'(CYCLES - 1);
            cal_done <= 1'b0;
          end
        end
        CAL_RUN:
        begin
          // retriggers while running are ignored
          if (count_r == '0)
          begin
            state_r  <= CAL_IDLE;
            cal_done <= 1'b1; // see (RL9)
          end
          else
          begin
            count_r <= count_r - 1'b1;
          end
        end
      endcase
    end
  end

  assign cal_busy = (state_r == CAL_RUN);

endmodule // dcc_cal

`default_nettype wire

/* dcc_host.sv */
// serial host model that frames register accesses toward the block
`timescale 1ns/1ps
`default_nettype none

module dcc_host
(
  input  wire logic clk_sys,
  output var  logic sclk,
  output var  logic sync_b,
  output var  logic sdi,
  input  wire logic sdo
);
  //------------------------------------------------------------------
  // frame generator
  //------------------------------------------------------------------
  initial
  begin
    sclk = 1'b1;
    sync_b = 1'b1;
    sdi = 1'b0;
  end

  // msb first, data taken by the block on the fall; read bits sampled before each rise
  task automatic frame(input logic [31:0] word, input int nbits, output logic [23:0] rdata);
    int k;
    rdata = 24'h000000;
    @(negedge clk_sys);
    sync_b = 1'b0;
    for (k = 1; k <= nbits; k++)
    begin
      sdi = word[32-k];
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk = 1'b0;
      repeat (4) @(negedge clk_sys);
      if (k >= 9)
        rdata[32-k] = sdo;
    end
    sclk = 1'b1;
    repeat (4) @(negedge clk_sys);
    sync_b = 1'b1;
    // no pull on the data line, so it must not keep its last value
    sdi = ~sdi;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule // dcc_host

`default_nettype wire

/* dcc_pkg.sv */
// constants and types shared by the converter configuration and calibration control
//------------------------------------------------------------------
// What this block does
// (RL1) The output code is the top resolution bits of the left-justified data word and drives the converter.
// (RL2) The host sets the reference span field in the main configuration to match its references, 0100 for +5 V/-5 V.
// (RL3) All supply monitor good levels are ANDed, and the block stays in reset unless every one is high.
// (RL4) Reset puts every register at its default and the output code at zero scale.
// (RL5) A 1 in bit 4 of the main configuration powers the converter down.
// (RL6) Temperature calibration is off after reset and is enabled by a 1 in bit 23 of the main configuration.
// (RL7) With calibration enabled, a 1 written to bit 8 of the action trigger runs one calibration cycle.
// (RL8) The host issues no output update while a calibration cycle runs.
// (RL9) Calibration completion reads back as bit 12 of the calibration status register.
// (RL10) With the alarm pin enable (bit 12 of main configuration) set, the active-low alarm goes low at the end of calibration.
// (RL11) The host should reload the code after calibration and recalibrate when temperature changes.
// (RL12) Deglitching is on after reset and is turned off by a 1 in bit 7 of the deglitch rate configuration.
// (RL13) The THD priority bit 10 of the main configuration resets to 1, and a 0 selects fast settling.
// (RL14) In fast settling the two-bit deglitch code mask bypasses deglitching for the selected code-change classes.
// (RL15) The deglitch code mask is writable only while THD priority is 0 and deglitch disable is 0.
// (RL16) Mask writes outside that condition are dropped and the mask keeps its value.
// (RL17) Each access is one 32-bit frame under the active-low select: read/write bit, 7-bit address, data.
//------------------------------------------------------------------
`default_nettype none

package dcc_pkg;

  localparam int          FRAME_BITS     = 32;
  localparam int          DATA_W         = 24;
  localparam int          ADDR_W         = 7;
  localparam int          CMD_BITS       = 8;
  localparam int          CNT_W          = 6;

  localparam logic [6:0]  ADDR_DAC       = 7'h01;
  localparam logic [6:0]  ADDR_CFG       = 7'h02;
  localparam logic [6:0]  ADDR_TRIG      = 7'h04;
  localparam logic [6:0]  ADDR_STAT      = 7'h05;
  localparam logic [6:0]  ADDR_DGR       = 7'h06;

  localparam int          CFG_CAL_EN_BIT = 23;
  localparam int          CFG_MASK_LSB   = 18;
  localparam int          CFG_ALARM_BIT  = 12;
  localparam int          CFG_THD_BIT    = 10;
  localparam int          CFG_SPAN_LSB   = 6;
  localparam int          CFG_PD_BIT     = 4;
  localparam int          TRIG_CAL_BIT   = 8;
  localparam int          STAT_DONE_BIT  = 12;
  localparam int          DGR_DIS_BIT    = 7;

  localparam logic [3:0]  SPAN_RST       = 4'h0;
  localparam logic [1:0]  MASK_RST       = 2'h0;
  localparam logic        THD_RST        = 1'b1;
  localparam logic [19:0] DAC_RST        = 20'h00000;

  localparam int          CLK_MHZ        = 50;
  localparam int          CAL_TIME_US    = 100;
  localparam int          CAL_CYCLES     = CAL_TIME_US * CLK_MHZ;
  localparam int          SMALL_STEP     = 256;

  typedef enum logic {CAL_IDLE, CAL_RUN} dcc_cal_state_type;

endpackage

`default_nettype wire

/* dcc_properties.sv */
// concurrent checks on the pins of the converter configuration control
`timescale 1ns/1ps
`default_nettype none

module dcc_properties
#(
  parameter int SUPPLIES = 5,
  parameter int RES      = 20,
  parameter int CAL_CYC  = 20
)
(
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic [SUPPLIES-1:0] supply_ok,
  input wire logic                sclk,
  input wire logic                sync_b,
  input wire logic                sdi,
  input wire logic                sdo,
  input wire logic                sdo_oe,
  input wire logic                alarm_b,
  input wire logic [RES-1:0]      dac_code,
  input wire logic                dac_update,
  input wire logic [3:0]          reference_span_select,
  input wire logic                converter_power_down,
  input wire logic                track_hold_en,
  input wire logic                cal_busy
);
  //------------------------------------------------------------------
  // calibration length counter and properties
  //------------------------------------------------------------------
  logic [15:0] busy_cnt_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!(rst_b && &supply_ok));

  // counts busy cycles; cleared while idle so each run starts from zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      busy_cnt_r <= 16'h0000;
    else if (cal_busy)
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    else
      busy_cnt_r <= 16'h0000;
  end

  a_reset_state : assert property (disable iff (1'b0)
    !(rst_b && &supply_ok) |-> dac_code == '0 && alarm_b && !cal_busy && track_hold_en)
    else $error("outputs not at reset values");
  a_code_update : assert property ($changed(dac_code) |-> dac_update && sync_b)
    else $error("code changed without an update");
  a_update_pulse : assert property (dac_update |=> !dac_update)
    else $error("update pulse longer than one cycle");
  a_cal_length : assert property ($fell(cal_busy) |-> busy_cnt_r == CAL_CYC)
    else $error("calibration length wrong");
  a_alarm_quiet : assert property (
    cal_busy && $past(cal_busy) && $past(cal_busy, 2) |-> alarm_b)
    else $error("alarm low during calibration");
  a_sdo_idle : assert property (sync_b [*5] |-> !sdo_oe && !sdo)
    else $error("serial output active outside a frame");
  a_oe_frame : assert property (!sync_b [*5] |-> sdo_oe)
    else $error("serial output not enabled in a frame");
  a_cfg_commit : assert property (
    $changed(reference_span_select) || $changed(converter_power_down)
    |-> sync_b && $past(sync_b, 2))
    else $error("configuration changed inside a frame");
  // deglitch disable drops the enable at once, so only a rise waits for an update
  a_track_update : assert property ($rose(track_hold_en) |-> dac_update)
    else $error("deglitch enable rose without update");
endmodule // dcc_properties

`default_nettype wire

/* dcc_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module dcc_sync
  import dcc_pkg::*;
#(
  parameter int W = 3
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r   <= '0;
      pin_sync <= '0;
    end
    else
    begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule // dcc_sync

`default_nettype wire

/* dcc_tb_top.sv */
// testbench top for the converter configuration and calibration control
`timescale 1ns/1ps
`default_nettype none

module dcc_tb_top;
  import dcc_pkg::*;
  //------------------------------------------------------------------
  // stimulus and checking
  //------------------------------------------------------------------
  localparam int SUP = 5;
  logic           clk_sys   = 1'b0;
  logic           rst_b     = 1'b1;
  logic [SUP-1:0] supply_ok = '1;
  logic [23:0]    rd;
  int             err_count = 0;
  int             tests_run = 0;
  wire logic      sclk, sync_b, sdi, sdo, sdo_oe, alarm_b, dac_update;
  wire logic      converter_power_down, track_hold_en, cal_busy;
  wire logic [19:0] dac_code;
  wire logic [3:0]  reference_span_select;

  always #10 clk_sys = ~clk_sys;

  dcc_top #(.SUPPLIES(SUP), .RES(20), .CAL_CYC(20)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .supply_ok(supply_ok), .sclk(sclk),
    .sync_b(sync_b), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .alarm_b(alarm_b),
    .dac_code(dac_code), .dac_update(dac_update),
    .reference_span_select(reference_span_select),
    .converter_power_down(converter_power_down), .track_hold_en(track_hold_en),
    .cal_busy(cal_busy));

  dcc_host u_host (.clk_sys(clk_sys), .sclk(sclk), .sync_b(sync_b), .sdi(sdi), .sdo(sdo));

  task automatic complete_run();
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    u_host.frame({1'b0, a, d}, 32, rd);
  endtask

  task automatic rdck(input string name, input logic [6:0] a, input logic [23:0] exp);
    u_host.frame({1'b1, a, 24'h000000}, 32, rd);
    check(name, rd, exp);
  endtask

  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 200 && cal_busy !== lvl; i++)
      @(negedge clk_sys);
    if (cal_busy !== lvl)
    begin
      err_count++;
      $display("[FAIL] cal_busy wait expected %b", lvl);
      complete_run();
    end
  endtask

  initial
  begin
    // reset falls just after time zero so every async reset sees the edge
    #1 rst_b = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("dac_code", dac_code, 24'h0);
    check("track_hold_en", track_hold_en, 24'h1);
    check("alarm_b", alarm_b, 24'h1);
    rdck("cfg", ADDR_CFG, 24'h000400);
    rdck("stat", ADDR_STAT, 24'h000000);
    rdck("dgr", ADDR_DGR, 24'h000000);
    wr(ADDR_CFG, 24'h0C0510); // span 0100
    check("span", reference_span_select, 24'h4);
    check("power_down", converter_power_down, 24'h1);
    rdck("cfg", ADDR_CFG, 24'h000510);
    wr(ADDR_CFG, 24'h000000);
    wr(ADDR_CFG, 24'h0C0000);
    rdck("cfg", ADDR_CFG, 24'h0C0000);
    wr(ADDR_DGR, 24'h000080);
    wr(ADDR_CFG, 24'h040000);
    rdck("cfg", ADDR_CFG, 24'h0C0000);
    wr(ADDR_DAC, 24'hABCDE0);
    check("dac_code", dac_code, 24'hABCDE);
    check("track_hold_en", track_hold_en, 24'h0);
    wr(ADDR_DGR, 24'h000000);
    wr(ADDR_CFG, 24'h080000);
    wr(ADDR_DAC, 24'hABCDF0);
    check("small step", track_hold_en, 24'h1);
    wr(ADDR_DAC, 24'h000000);
    check("large step", track_hold_en, 24'h0);
    wr(ADDR_CFG, 24'h040000);
    wr(ADDR_DAC, 24'h000010);
    check("small bypass", track_hold_en, 24'h0);
    wr(ADDR_CFG, 24'h040400);
    wr(ADDR_DAC, 24'h000020);
    check("thd priority", track_hold_en, 24'h1);
    // a misaligned commit of this frame would land in the code register
    u_host.frame({1'b0, ADDR_CFG, 24'h100010}, 31, rd);
    check("short frame", converter_power_down, 24'h0);
    check("short frame code", dac_code, 24'h2);
    rdck("cfg", ADDR_CFG, 24'h040400);
    rdck("unmapped", 7'h10, 24'h000000);
    wr(ADDR_TRIG, 24'h000100);
    check("cal disabled", cal_busy, 24'h0);
    wr(ADDR_CFG, 24'h881000);
    wr(ADDR_TRIG, 24'h000100);
    wait_busy(1'b1);
    wait_busy(1'b0); // no code update until done
    rdck("stat", ADDR_STAT, 24'h001000);
    check("alarm_b", alarm_b, 24'h0);
    wr(ADDR_DAC, 24'h123450); // reload after calibration
    check("dac_code", dac_code, 24'h12345);
    supply_ok[2] = 1'b0;
    @(negedge clk_sys);
    check("supply reset", dac_code, 24'h0);
    check("alarm_b", alarm_b, 24'h1);
    supply_ok[2] = 1'b1;
    repeat (3) @(negedge clk_sys);
    rdck("cfg", ADDR_CFG, 24'h000400);
    complete_run();
  end
endmodule // dcc_tb_top

bind dcc_top dcc_properties #(.SUPPLIES(SUPPLIES), .RES(RES), .CAL_CYC(CAL_CYC)) u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .supply_ok(supply_ok), .sclk(sclk), .sync_b(sync_b),
  .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .alarm_b(alarm_b), .dac_code(dac_code),
  .dac_update(dac_update), .reference_span_select(reference_span_select),
  .converter_power_down(converter_power_down), .track_hold_en(track_hold_en),
  .cal_busy(cal_busy));

`default_nettype wire

/* dcc_top.sv */
// serial register front end, configuration and calibration control
`timescale 1ns/1ps
`default_nettype none

module dcc_top
  import dcc_pkg::*;
#(
  parameter int SUPPLIES   = 5,
  parameter int RES        = 20,
  parameter int CAL_CYC    = CAL_CYCLES,
  parameter int STEP_SMALL = SMALL_STEP
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic [SUPPLIES-1:0] supply_ok,
  input  wire logic                sclk,
  input  wire logic                sync_b,
  input  wire logic                sdi,
  output logic                     sdo,
  output logic                     sdo_oe,
  output logic                     alarm_b,
  output logic [RES-1:0]           dac_code,
  output logic                     dac_update,
  output logic [3:0]               reference_span_select,
  output logic                     converter_power_down,
  output logic                     track_hold_en,
  output logic                     cal_busy
);

  //------------------------------------------------------------------
  // reset combine
  //------------------------------------------------------------------
  logic arst_b;

  // any monitor dropping holds the whole block in reset
  assign arst_b = rst_b & (&supply_ok); // see (RL3)

  //------------------------------------------------------------------
  // pin sampling and edge detect
  //------------------------------------------------------------------
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       sync_s;
  logic       sdi_s;
  logic       sclk_d_r;
  logic       sync_d_r;
  logic       sclk_fall;
  logic       sclk_rise;
  logic       frame_end;

  dcc_sync #(
    .W (3)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_b    (arst_b),
    .pin_in   ({sclk, ~sync_b, sdi}),
    .pin_sync (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign sync_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      sclk_d_r <= 1'b0;
      sync_d_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      sync_d_r <= sync_s;
    end
  end

  assign sclk_fall = sync_s & sclk_d_r & ~sclk_s;
  assign sclk_rise = sync_s & ~sclk_d_r & sclk_s;
  assign frame_end = sync_d_r & ~sync_s;

  //------------------------------------------------------------------
  // frame shifter
  //------------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_r;
  logic [CNT_W-1:0]      cnt_r;
  logic                  cmd_seen_r;
  logic                  wr_commit;
  logic [ADDR_W-1:0]     wr_addr;
  logic [DATA_W-1:0]     wr_data;

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      rx_r  <= '0;
      cnt_r <= '0;
    end
    else if (!sync_s)
    begin
      cnt_r <= '0;
    end
    else if (sclk_fall)
    begin
      rx_r <= {rx_r[FRAME_BITS-2:0], sdi_s};
      // saturate so an over-long frame never wraps back to 32
      if (cnt_r != '1)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // only a write frame of exactly 32 bits takes effect
  assign wr_commit = frame_end && (cnt_r == CNT_W'(FRAME_BITS)) && !rx_r[31]; // see (RL17)
  assign wr_addr   = rx_r[30:24];
  assign wr_data   = rx_r[DATA_W-1:0];

  //------------------------------------------------------------------
  // register state
  //------------------------------------------------------------------
  logic [19:0] dac_data_r;
  logic        cal_en_r;
  logic [1:0]  mask_r;
  logic        alarm_en_r;
  logic        thd_r;
  logic [3:0]  span_r;
  logic        pd_r;
  logic        dgl_dis_r;
  logic        cal_done;
  logic        cal_start;
  logic        mask_wr_ok;

  assign mask_wr_ok = thd_r == 1'b0 && dgl_dis_r == 1'b0; // see (RL15)

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      cal_en_r   <= 1'b0; // see (RL6)
      mask_r     <= MASK_RST;
      alarm_en_r <= 1'b0;
      thd_r      <= THD_RST; // see (RL13)
      span_r     <= SPAN_RST;
      pd_r       <= 1'b0;
    end
    else if (wr_commit && wr_addr == ADDR_CFG)
    begin
      cal_en_r   <= wr_data[CFG_CAL_EN_BIT]; // see (RL6)
      alarm_en_r <= wr_data[CFG_ALARM_BIT];
      thd_r      <= wr_data[CFG_THD_BIT]; // see (RL13)
      span_r     <= wr_data[CFG_SPAN_LSB+:4];
      pd_r       <= wr_data[CFG_PD_BIT]; // see (RL5)
      // gate uses the values before this write
      if (mask_wr_ok)
      begin
        mask_r <= wr_data[CFG_MASK_LSB+:2]; // see (RL14) see (RL16)
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      dgl_dis_r <= 1'b0; // see (RL12)
    end
    else if (wr_commit && wr_addr == ADDR_DGR)
    begin
      dgl_dis_r <= wr_data[DGR_DIS_BIT]; // see (RL12)
    end
  end

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      dac_data_r <= DAC_RST; // see (RL4)
    end
    else if (wr_commit && wr_addr == ADDR_DAC)
    begin
      dac_data_r <= wr_data[DATA_W-1:4];
    end
  end

  assign cal_start = wr_commit && wr_addr == ADDR_TRIG && wr_data[TRIG_CAL_BIT]; // see (RL7)

  dcc_cal #(
    .CYCLES (CAL_CYC)
  ) u_cal (
    .clk_sys    (clk_sys),
    .rst_b      (arst_b),
    .cal_enable (cal_en_r),
    .cal_start  (cal_start),
    .cal_busy   (cal_busy),
    .cal_done   (cal_done)
  );

  //------------------------------------------------------------------
  // converter side outputs
  //------------------------------------------------------------------
  logic [RES-1:0] new_code;
  logic [RES-1:0] delta;
  logic           small_step;
  logic           bypass;

  assign new_code   = wr_data[DATA_W-1 -: RES]; // see (RL1)
  assign delta      = (new_code > dac_code) ? new_code - dac_code : dac_code - new_code;
  assign small_step = delta < RES'(STEP_SMALL);
  // mask bit 0 bypasses small steps, bit 1 large steps
  assign bypass     = (mask_r[0] & small_step) | (mask_r[1] & ~small_step);

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      dac_code      <= '0; // see (RL4)
      dac_update    <= 1'b0;
      track_hold_en <= 1'b1; // see (RL12)
    end
    else
    begin
      dac_update <= wr_commit && wr_addr == ADDR_DAC;
      if (wr_commit && wr_addr == ADDR_DAC)
      begin
        dac_code      <= new_code; // see (RL1)
        track_hold_en <= ~dgl_dis_r & ~(~thd_r & bypass); // see (RL14)
      end
      else if (dgl_dis_r)
      begin
        track_hold_en <= 1'b0; // see (RL12)
      end
    end
  end

  assign reference_span_select = span_r;
  assign converter_power_down  = pd_r; // see (RL5)

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      alarm_b <= 1'b1;
    end
    else
    begin
      alarm_b <= ~(alarm_en_r & cal_done); // see (RL10)
    end
  end

  //------------------------------------------------------------------
  // read back
  //------------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] tx_r;

  always_comb
  begin
    rd_word = '0;
    unique case (rx_r[ADDR_W-1:0])
      ADDR_DAC:  rd_word = {dac_data_r, 4'h0};
      ADDR_CFG:
      begin
        rd_word[CFG_CAL_EN_BIT]  = cal_en_r;
        rd_word[CFG_MASK_LSB+:2] = mask_r;
        rd_word[CFG_ALARM_BIT]   = alarm_en_r;
        rd_word[CFG_THD_BIT]     = thd_r;
        rd_word[CFG_SPAN_LSB+:4] = span_r;
        rd_word[CFG_PD_BIT]      = pd_r;
      end
      ADDR_STAT: rd_word[STAT_DONE_BIT] = cal_done; // see (RL9)
      ADDR_DGR:  rd_word[DGR_DIS_BIT]   = dgl_dis_r;
      default:   rd_word = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_b)
  begin
    if (!arst_b)
    begin
      cmd_seen_r <= 1'b0;
      tx_r       <= '0;
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
    end
    else
    begin
      sdo_oe     <= sync_s;
      cmd_seen_r <= sclk_fall && cnt_r == CNT_W'(CMD_BITS - 1);
      if (!sync_s)
      begin
        sdo  <= 1'b0;
        tx_r <= '0;
      end
      else if (cmd_seen_r && rx_r[CMD_BITS-1])
      begin
        tx_r <= rd_word; // see (RL17)
      end
      else if (sclk_rise && cnt_r >= CNT_W'(CMD_BITS))
      begin
        sdo  <= tx_r[DATA_W-1];
        tx_r <= {tx_r[DATA_W-2:0], 1'b0};
      end
    end
  end

endmodule // dcc_top

`default_nettype wire
